// File: core/cnsd_top.sv
/*
  Node switch decode for a fieldbus coupler: samples the rate and node
  switch banks once after reset, decodes them, bounds process-data
  object counts, filters frame format, drives activity indicators and
  the alarm relay, and offers a small register port with interrupt.
  Assumes switch pins are asynchronous and static while powered; the
  protocol engine delivers one-cycle frame strobes on this clock.
*/
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module cnsd_top #(
  parameter int LED_CYCLES = cnsd_pkg::LED_PULSE_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  // Switch banks
  input wire logic [3:0] rate_switch,
  input wire logic [7:0] node_switch,
  // Protocol engine strobes
  input wire logic frame_sent,
  input wire logic frame_received,
  input wire logic frame_extended,
  input wire logic alarm_event,
  // Decoded configuration to the protocol engine
  output logic [3:0] rate_code,
  output logic [10:0] rate_kbps,
  output logic rate_auto,
  output logic rate_valid,
  output logic [6:0] node_id,
  output logic node_valid,
  output logic config_ready,
  output logic frame_accept,
  output logic [3:0] rx_pdo_count,
  output logic [3:0] tx_pdo_count,
  output logic [3:0] rtr_pdo_count,
  // Indicators and relay
  output logic led_tx,
  output logic led_rx,
  output logic led_alarm,
  output logic alarm_relay,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq
);
  // ---------------------------------------------------------------
  // Switch synchronisers
  // ---------------------------------------------------------------
  logic [11:0] sw_meta; // First stage, read only by sw_sync
  logic [11:0] sw_sync; // Second stage, safe to use

  // Two flops before any logic looks at the switch pins
  always_ff @(posedge clock)
  begin
    sw_meta <= {rate_switch, node_switch};
    sw_sync <= sw_meta;
  end

  // ---------------------------------------------------------------
  // Loader state machine
  // ---------------------------------------------------------------
  cnsd_pkg::cnsd_state_type state, next_state;
  logic [1:0] settle; // Sync chain fill counter
  logic [1:0] next_settle;
  logic [3:0] rate_q, next_rate_q;
  logic [7:0] node_q, next_node_q;

  // Bank value is plain binary, position 1 being bit 0
  function automatic logic is_rate_ok(input logic [3:0] c);
    is_rate_ok = (c <= cnsd_pkg::RATE_CODE_AUTO);
  endfunction

  // Settle, take one snapshot, then hold until the next reset
  always_comb
  begin
    next_state = state;
    next_settle = settle;
    next_rate_q = rate_q;
    next_node_q = node_q;
    case (state)
      cnsd_pkg::ST_SETTLE:
      begin
        next_settle = settle + 2'b01;
        if (settle == 2'(cnsd_pkg::SYNC_SETTLE_CYC - 1))
        begin
          next_state = cnsd_pkg::ST_SAMPLE;
        end
      end
      cnsd_pkg::ST_SAMPLE:
      begin
        next_rate_q = sw_sync[11:8];
        next_node_q = sw_sync[7:0];
        next_state = cnsd_pkg::ST_HOLD;
      end
      cnsd_pkg::ST_HOLD:
      begin
        next_state = cnsd_pkg::ST_HOLD; // Switch changes ignored
      end
      default:
      begin
        next_state = cnsd_pkg::ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state <= cnsd_pkg::ST_SETTLE;
      settle <= 2'b00;
      rate_q <= cnsd_pkg::RATE_CODE_DEF;
      node_q <= cnsd_pkg::NODE_DEF;
    end
    else
    begin
      state <= next_state;
      settle <= next_settle;
      rate_q <= next_rate_q;
      node_q <= next_node_q;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign config_ready = (state == cnsd_pkg::ST_HOLD);
  assign rate_code = rate_q;
  assign rate_auto = config_ready
    && (rate_q == cnsd_pkg::RATE_CODE_AUTO);
  assign rate_valid = config_ready && is_rate_ok(rate_q);
  // Fixed rate only for codes up to 8 (1000 kbit/s); auto and invalid show zero
  assign rate_kbps = (rate_q <= cnsd_pkg::RATE_CODE_MAX)
    ? cnsd_pkg::RATE_KBPS[rate_q] : 11'h000;
  // Zero and anything above 127 are refused
  assign node_valid = config_ready && (node_q != 8'h00)
    && (node_q <= cnsd_pkg::NODE_MAX);
  assign node_id = node_q[6:0];
  // Only base-format frames reach the object layer
  assign frame_accept = frame_received && !frame_extended;

  // ---------------------------------------------------------------
  // Registers: enables, alarm enables, object counts, scan result
  // ---------------------------------------------------------------
  logic [cnsd_pkg::EV_W-1:0] status, next_status;
  logic [cnsd_pkg::EV_W-1:0] irq_en, next_irq_en;
  logic [cnsd_pkg::EV_W-1:0] alarm_en, next_alarm_en;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic [3:0] rtr_cnt, next_rtr_cnt;
  logic [3:0] scan_code, next_scan_code;
  logic [31:0] next_rdata;
  logic [cnsd_pkg::EV_W-1:0] ev;
  logic clip;

  // Clamp a requested object count to its ceiling
  function automatic logic [3:0] clamp(input logic [3:0] v,
                                       input logic [3:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  assign clip = reg_write && (reg_addr == cnsd_pkg::ADDR_PDO_CNT)
    && ((reg_wdata[3:0] > cnsd_pkg::RX_PDO_MAX)
     || (reg_wdata[7:4] > cnsd_pkg::TX_PDO_MAX)
     || (reg_wdata[11:8] > cnsd_pkg::RTR_PDO_MAX)
     || (reg_wdata[11:8] > reg_wdata[7:4]));

  // Event vector feeding the sticky status
  always_comb
  begin
    ev = '0;
    ev[cnsd_pkg::EV_TX] = frame_sent;
    ev[cnsd_pkg::EV_RX] = frame_accept;
    ev[cnsd_pkg::EV_EXT] = frame_received && frame_extended;
    ev[cnsd_pkg::EV_CFG] = (state == cnsd_pkg::ST_SAMPLE)
      && (!is_rate_ok(sw_sync[11:8]) || sw_sync[7:0] == 8'h00
      || sw_sync[7:0] > cnsd_pkg::NODE_MAX);
    ev[cnsd_pkg::EV_PDO] = clip;
    ev[cnsd_pkg::EV_ALARM] = alarm_event;
  end

  // Register writes and read mux; set beats clear in the same cycle
  always_comb
  begin
    next_status = status;
    next_irq_en = irq_en;
    next_alarm_en = alarm_en;
    next_rx_cnt = rx_cnt;
    next_tx_cnt = tx_cnt;
    next_rtr_cnt = rtr_cnt;
    next_scan_code = scan_code;
    next_rdata = 32'h0000_0000;
    if (reg_write)
    begin
      case (reg_addr)
        cnsd_pkg::ADDR_CLEAR:
          next_status = status & ~reg_wdata[cnsd_pkg::EV_W-1:0];
        cnsd_pkg::ADDR_ENABLE:
          next_irq_en = reg_wdata[cnsd_pkg::EV_W-1:0];
        cnsd_pkg::ADDR_ALARM_EN:
          next_alarm_en = reg_wdata[cnsd_pkg::EV_W-1:0];
        cnsd_pkg::ADDR_PDO_CNT:
        begin
          // Ceilings hold whatever software asks for
          next_rx_cnt = clamp(reg_wdata[3:0], cnsd_pkg::RX_PDO_MAX);
          next_tx_cnt = clamp(reg_wdata[7:4], cnsd_pkg::TX_PDO_MAX);
          next_rtr_cnt = clamp(clamp(reg_wdata[11:8],
            cnsd_pkg::RTR_PDO_MAX), clamp(reg_wdata[7:4],
            cnsd_pkg::TX_PDO_MAX));
        end
        cnsd_pkg::ADDR_AUTO_RATE:
        begin
          // Scan result only accepted in auto mode and for a real rate
          if (rate_auto && reg_wdata[3:0] <= cnsd_pkg::RATE_CODE_MAX)
          begin
            next_scan_code = reg_wdata[3:0];
          end
        end
        default:
        begin
          next_status = status; // Unmapped or read-only: ignored
        end
      endcase
    end
    next_status = next_status | ev;
    if (reg_read)
    begin
      case (reg_addr)
        cnsd_pkg::ADDR_CONFIG:
          next_rdata = {5'h00, rate_auto, rate_valid, node_valid,
            config_ready, rate_kbps[6:0], 4'h0, rate_q, node_q};
        cnsd_pkg::ADDR_STATUS:
          next_rdata = 32'(status);
        cnsd_pkg::ADDR_ENABLE:
          next_rdata = 32'(irq_en);
        cnsd_pkg::ADDR_ALARM_EN:
          next_rdata = 32'(alarm_en);
        cnsd_pkg::ADDR_PDO_CNT:
          next_rdata = {20'h0_0000, rtr_cnt, tx_cnt, rx_cnt};
        cnsd_pkg::ADDR_AUTO_RATE:
          next_rdata = {17'h0_0000, rate_kbps, scan_code};
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      status <= '0;
      irq_en <= '0;
      alarm_en <= '0;
      rx_cnt <= cnsd_pkg::RX_PDO_MAX;
      tx_cnt <= cnsd_pkg::TX_PDO_MAX;
      rtr_cnt <= cnsd_pkg::RTR_PDO_MAX;
      scan_code <= 4'h0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      status <= next_status;
      irq_en <= next_irq_en;
      alarm_en <= next_alarm_en;
      rx_cnt <= next_rx_cnt;
      tx_cnt <= next_tx_cnt;
      rtr_cnt <= next_rtr_cnt;
      scan_code <= next_scan_code;
      reg_rdata <= next_rdata;
    end
  end

  assign rx_pdo_count = rx_cnt;
  assign tx_pdo_count = tx_cnt;
  assign rtr_pdo_count = rtr_cnt;
  assign irq = |(status & irq_en);
  // Relay follows any enabled pending event; the indicator mirrors it
  assign alarm_relay = |(status & alarm_en);
  assign led_alarm = alarm_relay;

  // ---------------------------------------------------------------
  // Activity indicators
  // ---------------------------------------------------------------
  cnsd_pulse #(.CYCLES(LED_CYCLES)) u_led_tx (
    .clock(clock),
    .sys_rst(sys_rst),
    .trig(frame_sent),
    .led(led_tx)
  );
  cnsd_pulse #(.CYCLES(LED_CYCLES)) u_led_rx (
    .clock(clock),
    .sys_rst(sys_rst),
    .trig(frame_received),
    .led(led_rx)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_HOLD_CFG: assert property (
    config_ready |=> $stable(rate_q) && $stable(node_q))
    else $error("Held config changed");
  AST_NODE_ZERO: assert property (
    (node_q == 8'h00) |-> !node_valid)
    else $error("Zero node accepted");
  AST_AUTO: assert property (
    rate_auto |-> rate_kbps == 11'h000 && rate_valid)
    else $error("Auto mode with fixed rate");
  AST_RATE_DEF: assert property (
    config_ready && rate_q == 4'h1 |-> rate_kbps == 11'd20)
    else $error("Code one not 20 kbit/s");
  AST_PDO_MAX: assert property (
    rx_cnt <= 4'h5 && tx_cnt <= 4'hA && rtr_cnt <= 4'h5)
    else $error("Object count above ceiling");
  AST_EXT_DROP: assert property (
    frame_extended |-> !frame_accept)
    else $error("Extended frame accepted");
  AST_ALARM: assert property (
    alarm_event && alarm_en[cnsd_pkg::EV_ALARM] |=> alarm_relay && led_alarm)
    else $error("Alarm relay not set");
  AST_TX_LED: assert property (
    frame_sent |=> led_tx [*2])
    else $error("Transmit indicator not lit");
  AST_RX_LED: assert property (
    frame_received |=> led_rx)
    else $error("Receive indicator not lit");
  AST_LOAD: assert property (
    state == cnsd_pkg::ST_SAMPLE |=> rate_q == $past(sw_sync[11:8])
      && node_q == $past(sw_sync[7:0]))
    else $error("Switch sample mismatch");
  AST_READY: assert property (
    $fell(sys_rst) |-> ##4 $rose(config_ready))
    else $error("Ready not raised on time");

  COV_AUTO: cover property (rate_auto);
  COV_ALARM: cover property (alarm_relay);
  COV_EXT: cover property (frame_received && frame_extended);
  COV_CLIP: cover property (clip);
endmodule
`default_nettype wire

// File: core/cnsd_pkg.sv
/*
  Shared constants for the fieldbus coupler node switch decode block:
  register offsets and fields, switch codes, rate table, timing counts.
  Assumes a single 125 MHz clock and a synchronous active-high reset.
*/
package cnsd_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00; // Decoded switch state, RO
  localparam logic [7:0] ADDR_STATUS = 8'h04; // Sticky events, RO
  localparam logic [7:0] ADDR_CLEAR = 8'h08; // Write one to clear, WO
  localparam logic [7:0] ADDR_ENABLE = 8'h0C; // Interrupt enable, RW
  localparam logic [7:0] ADDR_ALARM_EN = 8'h10; // Alarm event enable, RW
  localparam logic [7:0] ADDR_PDO_CNT = 8'h14; // Object counts, RW
  localparam logic [7:0] ADDR_AUTO_RATE = 8'h18; // Scan result, RW

  // ---------------------------------------------------------------
  // Event bit positions (status, clear, enable, alarm enable)
  // ---------------------------------------------------------------
  localparam int EV_TX = 0; // Message sent
  localparam int EV_RX = 1; // Message received
  localparam int EV_EXT = 2; // Extended frame rejected
  localparam int EV_CFG = 3; // Invalid switch setting
  localparam int EV_PDO = 4; // Object count request clipped
  localparam int EV_ALARM = 5; // External alarm-capable event
  localparam int EV_W = 6;

  // ---------------------------------------------------------------
  // Switch codes and limits
  // ---------------------------------------------------------------
  localparam logic [3:0] RATE_CODE_MAX = 4'h8; // Last fixed rate code
  localparam logic [3:0] RATE_CODE_AUTO = 4'h9; // Automatic scan
  localparam logic [3:0] RATE_CODE_DEF = 4'h1; // Factory default
  localparam logic [7:0] NODE_MAX = 8'h7F; // Highest valid node
  localparam logic [7:0] NODE_DEF = 8'h20; // Factory default node
  localparam logic [7:0] NODE_MAP_MAX = 8'h2A; // Full default mapping
  localparam logic [3:0] RX_PDO_MAX = 4'h5;
  localparam logic [3:0] TX_PDO_MAX = 4'hA;
  localparam logic [3:0] RTR_PDO_MAX = 4'h5;

  // ---------------------------------------------------------------
  // Rate table in kbit/s, index is the switch code
  // ---------------------------------------------------------------
  localparam logic [10:0] RATE_KBPS [0:8] = '{
    11'd10, 11'd20, 11'd50, 11'd100, 11'd125,
    11'd250, 11'd500, 11'd800, 11'd1000
  };

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int LED_PULSE_MS = 50; // Indicator on-time
  localparam int LED_PULSE_CYC = LED_PULSE_MS * CLK_MHZ * 1000;
  localparam int SYNC_SETTLE_CYC = 3; // Sync chain fill before sampling

  // Loader states, Gray coded along the path
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_HOLD = 2'b11
  } cnsd_state_type;

endpackage

// File: core/cnsd_pulse.sv
/*
  Indicator pulse stretcher: a one-cycle trigger lights the output for
  a fixed count of cycles; a retrigger restarts the count.
  Assumes triggers come from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module cnsd_pulse #(
  parameter int CYCLES = 6250000
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic trig,
  output logic led
);
  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  logic [31:0] count; // Remaining on-time
  logic [31:0] next_count;

  // Load on trigger, count down otherwise
  always_comb
  begin
    next_count = count;
    if (trig)
    begin
      next_count = 32'(CYCLES);
    end
    else if (count != 32'h0000_0000)
    begin
      next_count = count - 32'h0000_0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      count <= 32'h0000_0000;
    end
    else
    begin
      count <= next_count;
    end
  end

  assign led = (count != 32'h0000_0000); // Lit while counting
endmodule
`default_nettype wire

// File: tb/cnsd_net_model.sv
/*
  Behavioural model of the network side: turns one-cycle commands from
  the bench into protocol engine strobes (sent, received, alarm).
  Assumes the same clock and synchronous reset as the block.
*/
`timescale 1ns/100ps
`default_nettype none
module cnsd_net_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [1:0] kind,
  output logic frame_sent,
  output logic frame_received,
  output logic frame_extended,
  output logic alarm_event
);
  // -------------------------------------------------------------
  // Strobe generation
  // -------------------------------------------------------------
  // Kind 0 sent, 1 standard rx, 2 extended rx, 3 alarm event
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      frame_sent <= 1'b0;
      frame_received <= 1'b0;
      frame_extended <= 1'b0;
      alarm_event <= 1'b0;
    end
    else
    begin
      frame_sent <= go && (kind == 2'd0);
      frame_received <= go && (kind == 2'd1 || kind == 2'd2);
      alarm_event <= go && (kind == 2'd3);
      // Format flag toggles when unqualified, so no stale value helps
      if (go && kind == 2'd2)
        frame_extended <= 1'b1;
      else if (go && kind == 2'd1)
        frame_extended <= 1'b0;
      else
        frame_extended <= ~frame_extended;
    end
  end
endmodule
`default_nettype wire

// File: tb/can_node_switch_decode_tb.sv
/*
  Self-checking bench for the node switch decode block.
  Assumes the network model drives the frame strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module can_node_switch_decode_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] rate_switch = 4'h1;
  logic [7:0] node_switch = 8'h20;
  logic go = 1'b0;
  logic [1:0] kind = 2'd0;
  logic fs, fr, fx, ae;
  logic [3:0] rate_code, rxc, txc, rtc;
  logic [10:0] rate_kbps;
  logic [6:0] node_id;
  logic rate_auto, rate_valid, node_valid, config_ready, frame_accept;
  logic led_tx, led_rx, led_alarm, alarm_relay, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, rd;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  // 8 ns period
  always #4 clock = ~clock;

  cnsd_net_model net (.clock(clock), .sys_rst(sys_rst), .go(go),
    .kind(kind), .frame_sent(fs), .frame_received(fr),
    .frame_extended(fx), .alarm_event(ae));

  // Short indicator pulse keeps the run brief
  cnsd_top #(.LED_CYCLES(4)) dut (.clock(clock), .sys_rst(sys_rst),
    .rate_switch(rate_switch), .node_switch(node_switch),
    .frame_sent(fs), .frame_received(fr), .frame_extended(fx),
    .alarm_event(ae), .rate_code(rate_code), .rate_kbps(rate_kbps),
    .rate_auto(rate_auto), .rate_valid(rate_valid), .node_id(node_id),
    .node_valid(node_valid), .config_ready(config_ready),
    .frame_accept(frame_accept), .rx_pdo_count(rxc),
    .tx_pdo_count(txc), .rtr_pdo_count(rtc), .led_tx(led_tx),
    .led_rx(led_rx), .led_alarm(led_alarm), .alarm_relay(alarm_relay),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

  // -------------------------------------------------------------
  // Common tasks
  // -------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Hang guard: far beyond the few hundred cycles the tests need
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Command one strobe; returns once the block has taken it
  task automatic send(input logic [1:0] k);
    @(posedge clock);
    go <= 1'b1;
    kind <= k;
    @(posedge clock);
    go <= 1'b0;
    #1;
    if (k == 2'd1 || k == 2'd2)
      check(frame_accept, k == 2'd1);
    @(posedge clock);
    #1;
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // Reset with given switches, then check decode and that it is held
  task automatic apply_cfg(input logic [3:0] r, input logic [7:0] n);
    logic [10:0] tbl [0:8];
    logic [10:0] kb;
    logic nv;
    int w;
    tbl = '{11'd10, 11'd20, 11'd50, 11'd100, 11'd125, 11'd250,
      11'd500, 11'd800, 11'd1000};
    kb = (r <= 4'h8) ? tbl[r] : 11'd0;
    nv = (n != 8'h00) && (n <= 8'h7F);
    w = 0;
    @(posedge clock);
    rate_switch <= r;
    node_switch <= n;
    sys_rst <= 1'b1;
    settle();
    check(rate_code, 4'h1);
    check(node_id, 7'h20);
    // Release on an edge, as a synchronous reset source would
    @(posedge clock);
    sys_rst <= 1'b0;
    while (config_ready !== 1'b1 && w < 20)
    begin
      @(posedge clock);
      #1;
      w++;
    end
    check(w, 4);
    check(config_ready, 1'b1);
    check(rate_code, r);
    check(rate_kbps, kb);
    check(rate_auto, r == 4'h9);
    check(rate_valid, r <= 4'h9);
    check(node_valid, nv);
    check(node_id, n[6:0]);
    check({rxc, txc, rtc}, 12'h5A5);
    reg_rd(cnsd_pkg::ADDR_CONFIG);
    check(rd, {5'h00, r == 4'h9, r <= 4'h9, nv, 1'b1, kb[6:0],
      4'h0, r, n});
    // Only the bad-switch event can be pending straight after reset
    reg_rd(cnsd_pkg::ADDR_STATUS);
    check(rd, (r > 4'h9 || !nv) ? 32'h0000_0008 : 32'h0000_0000);
    @(posedge clock);
    rate_switch <= ~r;
    node_switch <= ~n;
    settle();
    check({rate_code, node_id}, {r, n[6:0]});
  endtask

  task automatic test_switches;
    logic [7:0] nodes [0:10];
    nodes = '{8'h00, 8'h01, 8'h20, 8'h2A, 8'h7F, 8'h80, 8'hFF, 8'h55,
      8'h02, 8'h40, 8'h7E};
    for (int i = 0; i < 11; i++)
      apply_cfg(i[3:0], nodes[i]);
    $display("switch decode test done");
  endtask

  task automatic test_frames;
    reg_wr(cnsd_pkg::ADDR_CLEAR, 32'h0000_003F);
    send(2'd0);
    check(led_tx, 1'b1);
    repeat (6) @(posedge clock);
    check(led_tx, 1'b0);
    send(2'd1);
    check(led_rx, 1'b1);
    reg_rd(cnsd_pkg::ADDR_STATUS);
    check(rd & 32'h0000_0007, 32'h0000_0003);
    reg_wr(cnsd_pkg::ADDR_CLEAR, 32'h0000_003F);
    send(2'd2);
    reg_rd(cnsd_pkg::ADDR_STATUS);
    check(rd & 32'h0000_0007, 32'h0000_0004);
    reg_rd(8'hFC);
    check(rd, 32'h0000_0000);
    $display("frame test done");
  endtask

  task automatic test_alarm;
    reg_wr(cnsd_pkg::ADDR_CLEAR, 32'h0000_003F);
    reg_wr(cnsd_pkg::ADDR_ENABLE, 32'h0000_0001);
    reg_wr(cnsd_pkg::ADDR_ALARM_EN, 32'h0000_0020);
    send(2'd0);
    check(irq, 1'b1);
    check(alarm_relay, 1'b0);
    send(2'd3);
    check({alarm_relay, led_alarm}, 2'b11);
    reg_wr(cnsd_pkg::ADDR_CLEAR, 32'h0000_0001);
    settle();
    check({irq, alarm_relay}, 2'b01);
    reg_wr(cnsd_pkg::ADDR_CLEAR, 32'h0000_0020);
    settle();
    check({alarm_relay, led_alarm}, 2'b00);
    reg_wr(cnsd_pkg::ADDR_ENABLE, 32'h0000_0000);
    send(2'd1);
    check({irq, alarm_relay}, 2'b00);
    $display("alarm test done");
  endtask

  // Over-range requests are clipped, transmit limit caps rtr
  task automatic test_pdo;
    reg_wr(cnsd_pkg::ADDR_CLEAR, 32'h0000_003F);
    reg_wr(cnsd_pkg::ADDR_PDO_CNT, 32'h0000_0FFF);
    settle();
    check({rtc, txc, rxc}, 12'h5A5);
    reg_rd(cnsd_pkg::ADDR_PDO_CNT);
    check(rd, 32'h0000_05A5);
    reg_rd(cnsd_pkg::ADDR_STATUS);
    check(rd & 32'h0000_0010, 32'h0000_0010);
    reg_wr(cnsd_pkg::ADDR_PDO_CNT, 32'h0000_0423);
    settle();
    check({rtc, txc, rxc}, 12'h223);
    reg_wr(cnsd_pkg::ADDR_PDO_CNT, 32'h0000_05A5);
    settle();
    check({rtc, txc, rxc}, 12'h5A5);
    $display("object count test done");
  endtask

  // Scan result register takes a fixed code only in auto mode
  task automatic test_scan;
    reg_wr(cnsd_pkg::ADDR_AUTO_RATE, 32'h0000_0003);
    reg_rd(cnsd_pkg::ADDR_AUTO_RATE);
    check(rd, 32'h0000_0000);
    apply_cfg(4'h9, 8'h2A);
    reg_wr(cnsd_pkg::ADDR_AUTO_RATE, 32'h0000_0006);
    reg_rd(cnsd_pkg::ADDR_AUTO_RATE);
    check(rd, 32'h0000_0006);
    reg_wr(cnsd_pkg::ADDR_AUTO_RATE, 32'h0000_0009);
    reg_rd(cnsd_pkg::ADDR_AUTO_RATE);
    check(rd, 32'h0000_0006);
    $display("scan result test done");
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    test_switches();
    test_frames();
    test_alarm();
    test_pdo();
    test_scan();
    wrap_up();
  end
endmodule
`default_nettype wire
